// ### rtl/asc_serial_ctrl.sv
// async serial control: APB register file, transmitter sequencing, receiver flags
// assumes an APB master on CLK and an asynchronous receive pin
`timescale 1ns/1ps

module asc_serial_ctrl
    import asc_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // serial line
    input  wire logic        RXD_IN,
    output logic             TXD_OUT,
    output logic             TXD_OE_N,
    // interrupt
    output logic             IRQ
);

    // apb handshake: one wait state, read data captured at the first access edge
    logic        pready_reg;
    logic [31:0] prdata_reg;
    logic        pslverr_reg;
    wire  acc_first = PSEL & PENABLE & ~pready_reg;
    wire  acc_done  = PSEL & PENABLE & pready_reg;
    wire  bus_wr    = acc_done & PWRITE;
    wire  bus_rd    = acc_done & ~PWRITE;
    wire  hit_fmt   = PADDR == ADDR_FORMAT;
    wire  hit_en    = PADDR == ADDR_ENABLE;
    wire  hit_st    = PADDR == ADDR_STATUS;
    wire  hit_dat   = PADDR == ADDR_DATA;
    wire  mapped    = hit_fmt | hit_en | hit_st | hit_dat;

    // register state
    asc_format_t fmt_reg, fmt_next;
    asc_enable_t ctl_reg, ctl_next;
    logic [7:0]  tdr_reg, rdr_reg, rdr_next;
    logic        tx_empty_flag_reg, tc_reg, rx_full_flag_reg, idle_reg, ovr_reg, fe_reg;
    logic        tx_seen_reg, rx_seen_reg, pre_pend_reg, idle_armed_reg;
    logic        irq_reg;

    // transmitter state
    asc_tx_state_t tx_state_reg, tx_state_next;
    logic [11:0]   tx_cnt_reg;
    logic [10:0]   tx_shift_reg, tx_shift_next;
    logic [3:0]    tx_left_reg, tx_left_next;
    logic          oe_n_reg;

    // receiver state
    asc_rx_state_t rx_state_reg;
    logic [2:0]    rx_sync_reg;
    logic          rx_line_reg;
    logic [11:0]   rx_cnt_reg;
    logic [3:0]    rx_left_reg, ones_reg;
    logic [9:0]    rx_shift_reg;

    wire [3:0] flen = frame_len(fmt_reg.word9);
    wire [7:0] status_byte = {tx_empty_flag_reg, tc_reg, rx_full_flag_reg, idle_reg, ovr_reg, 1'b0, fe_reg, 1'b0};
    wire [7:0] fmt_byte = {fmt_reg.rx_ninth_bit, fmt_reg.tx_ninth_bit, 1'b0, fmt_reg.word9,
                           fmt_reg.wake_addr, 3'h0};
    wire [7:0] rd_mux = hit_fmt ? fmt_byte :
                        hit_en  ? ctl_reg  :
                        hit_st  ? status_byte :
                        hit_dat ? rdr_reg  : 8'h00;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= acc_first;
            pslverr_reg <= acc_first & ~mapped;
            if (acc_first) begin
                prdata_reg <= {24'h00_0000, rd_mux};
            end
        end
    end

    // transmitter bit boundary and frame decisions
    wire tx_tick    = tx_cnt_reg == 12'h000;
    wire tx_decide  = tx_tick & (tx_left_reg <= 4'h1);
    wire tx_active  = (tx_state_reg == TX_PRE) | (tx_state_reg == TX_DATA) |
                      (tx_state_reg == TX_BRK) | (tx_state_reg == TX_GUARD);
    wire tx_load    = tx_decide & (tx_state_next == TX_DATA);
    wire tx_finish  = tx_decide & tx_active & ((tx_state_next == TX_MARK) | (tx_state_next == TX_OFF));
    wire pre_load   = tx_decide & (tx_state_next == TX_PRE);
    wire [10:0] data_frame = fmt_reg.word9 ? {1'b1, fmt_reg.tx_ninth_bit, tdr_reg, 1'b0}
                                           : {2'b11, tdr_reg, 1'b0};

    always_comb begin
        tx_state_next = tx_state_reg;
        tx_shift_next = tx_shift_reg;
        tx_left_next  = tx_left_reg;
        if (tx_decide) begin
            tx_left_next = flen;
            if (tx_state_reg == TX_BRK && !ctl_reg.break_send_ctl && ctl_reg.tx_enable) begin
                tx_state_next = TX_GUARD;
                tx_shift_next = 11'h7FF;
                tx_left_next  = 4'h1;
            end else if (!ctl_reg.tx_enable) begin
                tx_state_next = TX_OFF;
                tx_shift_next = 11'h7FF;
                tx_left_next  = 4'h1;
            end else if (pre_pend_reg) begin
                tx_state_next = TX_PRE;
                tx_shift_next = 11'h7FF;
            end else if (ctl_reg.break_send_ctl) begin
                tx_state_next = TX_BRK;
                tx_shift_next = 11'h000;
            end else if (!tx_empty_flag_reg) begin
                tx_state_next = TX_DATA;
                tx_shift_next = data_frame;
            end else begin
                tx_state_next = TX_MARK;
                tx_shift_next = 11'h7FF;
                tx_left_next  = 4'h1;
            end
        end else if (tx_tick) begin
            tx_shift_next = {1'b1, tx_shift_reg[10:1]};
            tx_left_next  = tx_left_reg - 4'h1;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tx_state_reg <= TX_OFF;
            tx_cnt_reg   <= 12'h000;
            tx_shift_reg <= 11'h7FF;
            tx_left_reg  <= 4'h1;
            oe_n_reg     <= 1'b1;
        end else begin
            tx_cnt_reg   <= tx_tick ? BIT_LAST : tx_cnt_reg - 12'h001;
            tx_state_reg <= tx_state_next;
            tx_shift_reg <= tx_shift_next;
            tx_left_reg  <= tx_left_next;
            oe_n_reg     <= tx_state_next == TX_OFF;
        end
    end

    // receiver: three-stage synchroniser, change accepted when stages two and three agree
    wire rx_tick   = rx_cnt_reg == 12'h000;
    wire rx_run    = ctl_reg.rx_enable;
    wire rx_sample = rx_run & (rx_state_reg == RX_SHIFT) & rx_tick;
    wire rx_end    = rx_sample & (rx_left_reg == 4'h1);
    wire [9:0] rx_full  = {rx_line_reg, rx_shift_reg[9:1]};
    wire [7:0] rx_data  = fmt_reg.word9 ? rx_full[7:0] : rx_full[8:1];
    wire       rx_msb   = rx_full[8];
    wire       rx_stop  = rx_full[9];
    wire       sleeping = ctl_reg.rx_sleep_on;
    wire       line_idle = ones_reg >= flen;
    wire idle_event = rx_run & (rx_state_reg == RX_HUNT) & rx_tick & rx_line_reg &
                      (ones_reg == flen - 4'h1);
    wire wake_idle  = idle_event & sleeping & ~fmt_reg.wake_addr;
    wire wake_addr  = rx_end & sleeping & fmt_reg.wake_addr & rx_msb;
    wire rx_accept  = rx_end & (~sleeping | wake_addr);
    wire rx_store   = rx_accept & ~rx_full_flag_reg;
    wire ovr_set    = rx_accept & rx_full_flag_reg;
    wire fe_set     = rx_store & ~rx_stop;
    wire idle_set   = idle_event & ~sleeping & idle_armed_reg;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rx_sync_reg  <= 3'h7;
            rx_line_reg  <= 1'b1;
            rx_state_reg <= RX_HUNT;
            rx_cnt_reg   <= BIT_LAST;
            rx_left_reg  <= 4'h0;
            ones_reg     <= 4'h0;
            rx_shift_reg <= 10'h3FF;
        end else begin
            rx_sync_reg <= {rx_sync_reg[1:0], RXD_IN};
            if (rx_sync_reg[1] == rx_sync_reg[2]) begin
                rx_line_reg <= rx_sync_reg[2];
            end
            if (!rx_run) begin
                rx_state_reg <= RX_HUNT;
                rx_cnt_reg   <= BIT_LAST;
                ones_reg     <= 4'h0;
            end else if (rx_state_reg == RX_HUNT) begin
                if (!rx_line_reg) begin
                    rx_state_reg <= RX_SHIFT;
                    rx_cnt_reg   <= START_MID;
                    rx_left_reg  <= flen - 4'h1;
                    ones_reg     <= 4'h0;
                end else begin
                    rx_cnt_reg <= rx_tick ? BIT_LAST : rx_cnt_reg - 12'h001;
                    if (rx_tick && !line_idle) begin
                        ones_reg <= ones_reg + 4'h1;
                    end
                end
            end else if (rx_tick) begin
                rx_shift_reg <= rx_full;
                rx_left_reg  <= rx_left_reg - 4'h1;
                rx_cnt_reg   <= BIT_LAST;
                if (rx_left_reg == 4'h1) begin
                    rx_state_reg <= RX_HUNT;
                    ones_reg     <= rx_stop ? 4'h1 : 4'h0;
                end
            end else begin
                rx_cnt_reg <= rx_cnt_reg - 12'h001;
            end
        end
    end

    // format register keeps its content through reset
    always_comb begin
        fmt_next = fmt_reg;
        rdr_next = rdr_reg;
        if (bus_wr && hit_fmt) begin
            fmt_next.tx_ninth_bit = PWDATA[FMT_TX9_POS];
            fmt_next.word9        = PWDATA[FMT_WORD_POS];
            fmt_next.wake_addr    = PWDATA[FMT_WAKE_POS];
        end
        if (rx_store) begin
            fmt_next.rx_ninth_bit = rx_msb;
            rdr_next              = rx_data;
        end
    end

    always_ff @(posedge CLK) begin
        fmt_reg <= fmt_next;
        rdr_reg <= rdr_next;
    end

    // enable register; a software write of the sleep bit wins over a wake in the same cycle
    always_comb begin
        ctl_next = ctl_reg;
        if (bus_wr && hit_en) begin
            ctl_next = PWDATA[7:0];
            if (!ctl_reg.rx_sleep_on && !fmt_reg.wake_addr && line_idle) begin
                ctl_next.rx_sleep_on = 1'b0;
            end
        end else if (wake_idle || wake_addr) begin
            ctl_next.rx_sleep_on = 1'b0;
        end
    end

    // flag clear sequence: status read with the flag set, then data access
    wire tx_clr = bus_wr & hit_dat & tx_seen_reg;
    wire rx_clr = bus_rd & hit_dat & rx_seen_reg;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctl_reg        <= ENABLE_RESET;
            tdr_reg        <= 8'h00;
            tx_empty_flag_reg       <= 1'b1;
            tc_reg         <= 1'b1;
            rx_full_flag_reg       <= 1'b0;
            idle_reg       <= 1'b0;
            ovr_reg        <= 1'b0;
            fe_reg         <= 1'b0;
            tx_seen_reg    <= 1'b0;
            rx_seen_reg    <= 1'b0;
            pre_pend_reg   <= 1'b0;
            idle_armed_reg <= 1'b1;
            irq_reg        <= 1'b0;
        end else begin
            ctl_reg <= ctl_next;
            if (bus_wr && hit_dat) begin
                tdr_reg <= PWDATA[7:0];
            end
            // set wins over clear on every flag
            pre_pend_reg <= (pre_pend_reg & ~pre_load) |
                            (bus_wr & hit_en & PWDATA[3] & ~ctl_reg.tx_enable);
            tx_empty_flag_reg <= (tx_empty_flag_reg & ~tx_clr) | tx_load;
            tc_reg   <= (tc_reg & ~tx_clr) | tx_finish;
            rx_full_flag_reg <= (rx_full_flag_reg & ~rx_clr) | rx_store;
            ovr_reg  <= (ovr_reg & ~rx_clr) | ovr_set;
            fe_reg   <= (fe_reg & ~rx_clr) | fe_set;
            idle_reg <= (idle_reg & ~rx_clr) | idle_set;
            idle_armed_reg <= (idle_armed_reg & ~idle_set) | rx_store;
            if (bus_rd && hit_st) begin
                tx_seen_reg <= tx_empty_flag_reg | tc_reg;
                rx_seen_reg <= rx_full_flag_reg | idle_reg | ovr_reg | fe_reg;
            end else begin
                tx_seen_reg <= tx_seen_reg & ~(bus_wr & hit_dat);
                rx_seen_reg <= rx_seen_reg & ~(bus_rd & hit_dat);
            end
            irq_reg <= (ctl_reg.tx_empty_irq_en & tx_empty_flag_reg) |
                       (ctl_reg.tx_done_irq_en & tc_reg) |
                       (ctl_reg.rx_full_irq_en & (rx_full_flag_reg | ovr_reg)) |
                       (ctl_reg.line_quiet_irq_en & idle_reg);
        end
    end

    assign PRDATA   = prdata_reg;
    assign PREADY   = pready_reg;
    assign PSLVERR  = pslverr_reg;
    assign TXD_OUT  = tx_shift_reg[0];
    assign TXD_OE_N = oe_n_reg;
    assign IRQ      = irq_reg;

    // checks
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_access;
        PSEL && PENABLE;
    endsequence

    AST_APB_ANSWER: assert property (@(posedge CLK) disable iff (RST)
        s_setup ##1 s_access |=> PREADY)
        else $error("apb access not answered after one wait state");

    AST_FMT_ZERO: assert property (@(posedge CLK) disable iff (RST)
        PREADY && !PWRITE && hit_fmt |-> (PRDATA[7:0] & FMT_UNUSED_MASK) == 8'h00)
        else $error("unused format bits read non-zero");

    AST_IRQ_MASKED: assert property (@(posedge CLK) disable iff (RST)
        ctl_reg[7:4] == 4'h0 |=> !IRQ)
        else $error("interrupt raised with all enables clear");

    AST_IRQ_RX: assert property (@(posedge CLK) disable iff (RST)
        ctl_reg.rx_full_irq_en && (ovr_reg || rx_full_flag_reg) |=> IRQ)
        else $error("receive interrupt missing");

    AST_PRE_HIGH: assert property (@(posedge CLK) disable iff (RST)
        tx_state_reg == TX_PRE |-> TXD_OUT && !TXD_OE_N)
        else $error("preamble not driven high");

    AST_BRK_LOW: assert property (@(posedge CLK) disable iff (RST)
        tx_state_reg == TX_BRK |-> !TXD_OUT)
        else $error("break bit not low");

    AST_BRK_GUARD: assert property (@(posedge CLK) disable iff (RST)
        tx_decide && tx_state_reg == TX_BRK && ctl_reg.tx_enable && !ctl_reg.break_send_ctl
        |=> tx_state_reg == TX_GUARD && TXD_OUT)
        else $error("no high bit after break");

    AST_RELEASE_AT_END: assert property (@(posedge CLK) disable iff (RST)
        $rose(TXD_OE_N) |-> $past(tx_decide) && !$past(ctl_reg.tx_enable))
        else $error("pin released mid frame");

    AST_RX_OFF: assert property (@(posedge CLK) disable iff (RST)
        !ctl_reg.rx_enable && !rx_full_flag_reg |=> !rx_full_flag_reg)
        else $error("receive flag set while receiver disabled");

    AST_SLEEP_QUIET: assert property (@(posedge CLK) disable iff (RST)
        sleeping && !idle_reg |=> !idle_reg)
        else $error("idle flag set while sleeping");

    AST_ADDR_WAKE: assert property (@(posedge CLK) disable iff (RST)
        wake_addr && !rx_full_flag_reg && !(bus_wr && hit_en) |=> !ctl_reg.rx_sleep_on && rx_full_flag_reg)
        else $error("address bit did not wake and store");

endmodule : asc_serial_ctrl

// ### include/asc_pkg.sv
// constants, register map and carrier types of the async serial control block
// assumes a 50 MHz bus clock and an APB master with 32-bit data
package asc_pkg;

    // register indices; byte address on APB is four times the index
    localparam logic [7:0] IDX_FORMAT  = 8'h0E;
    localparam logic [7:0] IDX_ENABLE  = 8'h0F;
    localparam logic [7:0] IDX_STATUS  = 8'h10;
    localparam logic [7:0] IDX_DATA    = 8'h11;
    localparam logic [7:0] ADDR_FORMAT = {IDX_FORMAT[5:0], 2'b00};
    localparam logic [7:0] ADDR_ENABLE = {IDX_ENABLE[5:0], 2'b00};
    localparam logic [7:0] ADDR_STATUS = {IDX_STATUS[5:0], 2'b00};
    localparam logic [7:0] ADDR_DATA   = {IDX_DATA[5:0], 2'b00};

    // field positions of the format register
    localparam int FMT_RX9_POS  = 7;
    localparam int FMT_TX9_POS  = 6;
    localparam int FMT_WORD_POS = 4;
    localparam int FMT_WAKE_POS = 3;
    localparam logic [7:0] FMT_UNUSED_MASK = 8'h27;

    // values after reset
    localparam logic [7:0] ENABLE_RESET = 8'h00;

    // bit timing: fixed line rate, the block divides CLK by BIT_CYCLES in its own bit counters
    localparam int CLK_HZ     = 50_000_000;
    localparam int LINE_BAUD  = 115_200;
    localparam int BIT_CYCLES = CLK_HZ / LINE_BAUD;
    localparam int HALF_BIT   = BIT_CYCLES / 2;
    localparam logic [11:0] BIT_LAST  = 12'(BIT_CYCLES - 1);
    localparam logic [11:0] START_MID = 12'(BIT_CYCLES + HALF_BIT - 1);

    // frame lengths in bits, start and stop included
    localparam logic [3:0] FRAME_LEN8 = 4'hA;
    localparam logic [3:0] FRAME_LEN9 = 4'hB;

    typedef struct packed {
        logic tx_empty_irq_en;
        logic tx_done_irq_en;
        logic rx_full_irq_en;
        logic line_quiet_irq_en;
        logic tx_enable;
        logic rx_enable;
        logic rx_sleep_on;
        logic break_send_ctl;
    } asc_enable_t;

    typedef struct packed {
        logic rx_ninth_bit;
        logic tx_ninth_bit;
        logic word9;
        logic wake_addr;
    } asc_format_t;

    typedef enum logic [2:0] {
        TX_OFF   = 3'h0,
        TX_MARK  = 3'h1,
        TX_PRE   = 3'h2,
        TX_DATA  = 3'h3,
        TX_BRK   = 3'h4,
        TX_GUARD = 3'h5
    } asc_tx_state_t;

    typedef enum logic {
        RX_HUNT  = 1'b0,
        RX_SHIFT = 1'b1
    } asc_rx_state_t;

    function automatic logic [3:0] frame_len(input logic word9);
        frame_len = word9 ? FRAME_LEN9 : FRAME_LEN8;
    endfunction : frame_len

endpackage : asc_pkg

// ### tb/asc_remote.sv
// remote serial device: sends frames into the receive pin and decodes frames seen on the transmit pin
// assumes the block's CLK and the package bit time; no pull on the line, a released pin reads inverted
`timescale 1ns/1ps
module asc_remote
    import asc_pkg::*;
(
    // clock
    input  wire logic       CLK,
    // line from the block and the nine-bit word select
    input  wire logic       TXD_OUT,
    input  wire logic       TXD_OE_N,
    input  wire logic       word9,
    // line to the block and decoded frames
    output logic            rxd,
    output logic            in_frame,
    output logic [8:0]      got_data,
    output logic            got_stop,
    output int              got_n
);
    logic [8:0] sh;
    // with no pull a released pin is undefined, so show the inverse of its last level
    wire logic  line = TXD_OE_N ? ~TXD_OUT : TXD_OUT;

    initial begin
        rxd = 1'b1;
        in_frame = 1'b0;
        got_n = 0;
        got_stop = 1'b0;
        got_data = 9'h000;
    end

    // caller must be just past a rising edge
    task automatic send(input logic [8:0] d, input logic w9);
        logic [10:0] f;
        f = w9 ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
        for (int i = 0; i < (w9 ? 11 : 10); i++) begin
            rxd <= f[i];
            repeat (BIT_CYCLES) @(posedge CLK);
        end
    endtask : send

    // only a driven falling edge starts a frame; sampling at mid bit
    always begin
        @(negedge line iff !TXD_OE_N);
        in_frame = 1'b1;
        sh = 9'h000;
        repeat (HALF_BIT) @(posedge CLK);
        for (int i = 0; i < (word9 ? 9 : 8); i++) begin
            repeat (BIT_CYCLES) @(posedge CLK);
            sh[i] = line;
        end
        repeat (BIT_CYCLES) @(posedge CLK);
        got_stop = line;
        got_data = sh;
        got_n++;
        in_frame = 1'b0;
    end
endmodule : asc_remote

// ### tb/async_serial_control_tb.sv
// self-checking bench: APB register access, transmit sequencing, receive flags and wake-up
// assumes the remote model on the serial pins; long bit times are kept, run stays near 64k cycles
`timescale 1ns/1ps
module async_serial_control_tb;
    import asc_pkg::*;
    localparam int PRE_LO = FRAME_LEN9 * BIT_CYCLES - 4;
    localparam int PRE_HI = (FRAME_LEN9 + 1) * BIT_CYCLES + 4;
    logic        CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic        RXD_IN, TXD_OUT, TXD_OE_N, IRQ, word9, last_err, in_frame, got_stop;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [8:0]  got_data;
    int          err_count, samples_checked, got_n, n;
    logic [7:0]  irq_en [5] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h00};
    logic        irq_exp [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

    asc_serial_ctrl DUT (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .RXD_IN(RXD_IN), .TXD_OUT(TXD_OUT), .TXD_OE_N(TXD_OE_N), .IRQ(IRQ));
    asc_remote remote (.CLK(CLK), .TXD_OUT(TXD_OUT), .TXD_OE_N(TXD_OE_N), .word9(word9), .rxd(RXD_IN),
        .in_frame(in_frame), .got_data(got_data), .got_stop(got_stop), .got_n(got_n));

    always #10 CLK = ~CLK;

    task test_done;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask : chk

    // holds the request until pready is sampled high, then idles one cycle
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        int k;
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        k = 0;
        do begin
            @(posedge CLK);
            k++;
        end while (PREADY !== 1'b1 && k < 16);
        rd = PRDATA;
        last_err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (k >= 16) begin
            err_count++;
            test_done();
        end
        @(posedge CLK);
    endtask : xfer

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        chk(nm, e, rd & m);
    endtask : rdchk

    // waits for a frame start, or for a decoded frame; n counts the cycles
    task automatic wait_ev(input bit want_got, input int lim);
        int n0;
        n0 = got_n;
        n = 0;
        while (!(want_got ? got_n != n0 : in_frame === 1'b1) && n < lim) begin
            @(posedge CLK);
            n++;
        end
        if (n >= lim) begin
            err_count++;
            test_done();
        end
    endtask : wait_ev

    initial begin
        #1_900_000;
        err_count++;
        test_done();
    end

    initial begin
        CLK = 1'b0;
        RST = 1'b1;
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        word9 = 1'b0;
        err_count = 0;
        samples_checked = 0;
        repeat (8) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        rdchk("enable reset", ADDR_ENABLE, 32'hFF, 32'h00);
        rdchk("status reset", ADDR_STATUS, 32'hFF, 32'hC0);
        xfer(8'h00, 1'b0, 32'h0);
        chk("unmapped err", 32'h1, 32'(last_err));
        chk("unmapped data", 32'h0, rd);
        xfer(ADDR_FORMAT, 1'b1, 32'hFF);
        rdchk("format", ADDR_FORMAT, 32'h7F, 32'h58);
        xfer(ADDR_ENABLE, 1'b1, 32'hF0);
        repeat (3) @(posedge CLK);
        chk("irq all enables", 32'h1, 32'(IRQ));
        RST <= 1'b1;
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        chk("irq after reset", 32'h0, 32'(IRQ));
        rdchk("enable after reset", ADDR_ENABLE, 32'hFF, 32'h00);
        rdchk("format kept", ADDR_FORMAT, 32'h7F, 32'h58);
        for (int i = 0; i < 5; i++) begin
            xfer(ADDR_ENABLE, 1'b1, 32'(irq_en[i]));
            repeat (3) @(posedge CLK);
            chk("irq source mask", 32'(irq_exp[i]), 32'(IRQ));
        end
        // data waits before the enable, so preamble and then the frame follow
        word9 <= 1'b1;
        xfer(ADDR_FORMAT, 1'b1, 32'h50);
        rdchk("status", ADDR_STATUS, 32'h80, 32'h80);
        xfer(ADDR_DATA, 1'b1, 32'hA5);
        xfer(ADDR_ENABLE, 1'b1, 32'h08);
        wait_ev(1'b0, 7000);
        chk("preamble length", 32'h1, 32'(n >= PRE_LO && n <= PRE_HI));
        wait_ev(1'b1, 7000);
        chk("nine bit frame", 32'h1A5, 32'(got_data));
        chk("stop bit", 32'h1, 32'(got_stop));
        repeat (2 * BIT_CYCLES) @(posedge CLK);
        chk("idle driven", 32'h1, 32'({TXD_OE_N, TXD_OUT}));
        rdchk("tx done", ADDR_STATUS, 32'h40, 32'h40);
        word9 <= 1'b0;
        xfer(ADDR_FORMAT, 1'b1, 32'h00);
        xfer(ADDR_DATA, 1'b1, 32'h3C);
        wait_ev(1'b0, 7000);
        xfer(ADDR_ENABLE, 1'b1, 32'h00);
        wait_ev(1'b1, 7000);
        chk("frame after disable", 32'h03C, 32'(got_data));
        chk("stop after disable", 32'h1, 32'(got_stop));
        repeat (BIT_CYCLES) @(posedge CLK);
        chk("pin released", 32'h1, 32'(TXD_OE_N));
        xfer(ADDR_ENABLE, 1'b1, 32'h09);
        wait_ev(1'b0, 12000);
        xfer(ADDR_ENABLE, 1'b1, 32'h00);
        xfer(ADDR_ENABLE, 1'b1, 32'h08);
        wait_ev(1'b1, 7000);
        chk("break zeros", 32'h0, 32'({got_stop, got_data}));
        repeat (BIT_CYCLES) @(posedge CLK);
        chk("break guard", 32'h1, 32'(TXD_OUT));
        // enable dropped and raised inside the break frame: a fresh preamble comes before the data
        rdchk("tx empty", ADDR_STATUS, 32'h80, 32'h80);
        xfer(ADDR_DATA, 1'b1, 32'hC6);
        wait_ev(1'b0, 7000);
        chk("fresh preamble", 32'h1, 32'(n > 9 * BIT_CYCLES));
        wait_ev(1'b1, 7000);
        chk("frame after preamble", 32'h0C6, 32'(got_data));
        // receive side
        xfer(ADDR_ENABLE, 1'b1, 32'h24);
        remote.send(9'h05A, 1'b0);
        repeat (8) @(posedge CLK);
        chk("rx irq", 32'h1, 32'(IRQ));
        rdchk("rx full", ADDR_STATUS, 32'h20, 32'h20);
        rdchk("rx data", ADDR_DATA, 32'hFF, 32'h5A);
        repeat (3) @(posedge CLK);
        chk("rx irq cleared", 32'h0, 32'(IRQ));
        xfer(ADDR_ENABLE, 1'b1, 32'h00);
        remote.send(9'h033, 1'b0);
        repeat (8) @(posedge CLK);
        rdchk("rx off no flag", ADDR_STATUS, 32'h20, 32'h00);
        xfer(ADDR_ENABLE, 1'b1, 32'h04);
        repeat (11 * BIT_CYCLES) @(posedge CLK);
        xfer(ADDR_ENABLE, 1'b1, 32'h06);
        rdchk("sleep refused", ADDR_ENABLE, 32'hFF, 32'h04);
        rdchk("line quiet", ADDR_STATUS, 32'h10, 32'h10);
        xfer(ADDR_DATA, 1'b0, 32'h0);
        xfer(ADDR_FORMAT, 1'b1, 32'h08);
        xfer(ADDR_ENABLE, 1'b1, 32'h06);
        rdchk("sleep taken", ADDR_ENABLE, 32'hFF, 32'h06);
        remote.send(9'h012, 1'b0);
        repeat (8) @(posedge CLK);
        rdchk("asleep no flag", ADDR_STATUS, 32'h20, 32'h00);
        remote.send(9'h092, 1'b0);
        repeat (8) @(posedge CLK);
        rdchk("woken", ADDR_ENABLE, 32'hFF, 32'h04);
        rdchk("address full", ADDR_STATUS, 32'h20, 32'h20);
        rdchk("address byte", ADDR_DATA, 32'hFF, 32'h92);
        xfer(ADDR_FORMAT, 1'b1, 32'h00);
        xfer(ADDR_ENABLE, 1'b1, 32'h06);
        repeat (11 * BIT_CYCLES) @(posedge CLK);
        rdchk("idle wake", ADDR_ENABLE, 32'hFF, 32'h04);
        rdchk("no idle on wake", ADDR_STATUS, 32'h10, 32'h00);
        xfer(ADDR_FORMAT, 1'b1, 32'h10);
        remote.send(9'h1C3, 1'b1);
        repeat (8) @(posedge CLK);
        rdchk("rx ninth", ADDR_FORMAT, 32'h80, 32'h80);
        rdchk("rx nine data", ADDR_DATA, 32'hFF, 32'hC3);
        test_done();
    end
endmodule : async_serial_control_tb
